//--- core/ebp_pkg.sv
package ebp_pkg;
    // register indexes; the byte address is four times the index
    localparam logic [3:0] IDX_HIGH_DATA = 4'h0;
    localparam logic [3:0] IDX_HIGH_DIR = 4'h2;
    localparam logic [3:0] IDX_LOW_DATA = 4'h1;
    localparam logic [3:0] IDX_LOW_DIR = 4'h3;
    localparam logic [3:0] IDX_CTRL_DATA = 4'h8;
    localparam logic [3:0] IDX_CTRL_DIR = 4'h9;
    localparam logic [3:0] IDX_MODE_CFG = 4'hc;
    localparam logic [3:0] IDX_STATUS = 4'hd;
    localparam int EXP_REG_COUNT = 16;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // mode config field positions
    localparam int MODE_EXPANDED_BIT = 0;
    localparam int MODE_NARROW_BIT = 1;
    localparam int MODE_PERIPH_BIT = 2;
    localparam int MODE_FOLLOW_BIT = 3;
    localparam int MODE_EMULATE_BIT = 4;
    // bus cycle length in core clocks
    localparam int BUS_CYCLE_CLKS = 4;
    // pin to accepted input latency of the three stage synchroniser
    localparam int PIN_SYNC_CLKS = 4;

    typedef enum logic [1:0] {
        EBP_ACC_BYTE,
        EBP_ACC_WORD,
        EBP_ACC_MISALIGNED
    } ebp_size_t;
endpackage

//--- core/ebp_encode.sv
`timescale 1ns/1ps
// ========================================
// bus control encoder
module ebp_encode
    import ebp_pkg::*;
(
    input wire logic [1:0] size_i,
    input wire logic addr0_i,
    input wire logic read_i,
    output logic low_byte_strobe_o,
    output logic a0_o,
    output logic rw_o
);
    // strobe and a0 per access size
    always_comb begin
        rw_o = read_i; // RULE4
        case (size_i)
            EBP_ACC_WORD: begin
                low_byte_strobe_o = 1'b0; // RULE5
                a0_o = 1'b0;
            end
            EBP_ACC_MISALIGNED: begin
                low_byte_strobe_o = 1'b1; // RULE6
                a0_o = 1'b1;
            end
            default: begin
                low_byte_strobe_o = ~addr0_i; // RULE4
                a0_o = addr0_i;
            end
        endcase
    end
endmodule // ebp_encode

//--- core/ebp_port.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Functional notes
// [RULE1] internal paths are 16 bits; external bus is 8 or 16 wide
// [RULE2] every bus cycle shows its size on the low byte strobe
// [RULE3] follow-space narrow bit mixes 8 and 16 bit peripherals in wide mode
// [RULE4] byte access: even gives strobe 1 a0 0, odd strobe 0 a0 1
// [RULE5] aligned word: strobe 0, a0 0, rw 1 read 0 write
// [RULE6] only misaligned internal ram word gives strobe 1 a0 1, bytes swapped; the code does not swap the bytes
// [RULE7] peripheral mode removes the first sixteen expansion registers; the code keeps mode config and status on chip
// [RULE8] expanded modes move high and low port registers off chip
// [RULE9] expanded with emulate bit moves control port registers off chip
// [RULE10] high port pins carry address 15..8, data 15..8, narrow data 7..0
// [RULE11] high port is general io when not addressing; data always accessible
// [RULE12] direction 0 makes the pin an input, 1 an output
// [RULE13] low port carries address 7..0 and data 7..0, narrow address only
// [RULE14] narrow follow space acts as 8 bit bus through high port
// [RULE15] removed registers run as normal external cycles
// [RULE16] high port direction clears on reset
module ebp_port
    import ebp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // cpu external access request
    input wire logic cpu_req_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_read_i,
    input wire logic cpu_word_i,
    input wire logic cpu_ram_i,
    input wire logic cpu_follow_i,
    input wire logic [15:0] cpu_wdata_i,
    output logic cpu_done_o,
    output logic [15:0] cpu_rdata_o,
    // pins
    input wire logic [7:0] high_port_pins_i,
    output logic [7:0] high_port_pins_o,
    output logic [7:0] high_port_pins_oe_n_o,
    input wire logic [7:0] low_port_pins_i,
    output logic [7:0] low_port_pins_o,
    output logic [7:0] low_port_pins_oe_n_o,
    output logic low_byte_strobe_o,
    output logic a0_o,
    output logic rw_o,
    output logic bus_active_o
);
    // ========================================
    // registers
    logic [7:0] high_byte_port_data;
    logic [7:0] high_byte_port_direction;
    logic [7:0] low_byte_port_data;
    logic [7:0] low_byte_port_direction;
    logic [7:0] control_port_data;
    logic [7:0] control_port_direction;
    logic [7:0] mode_cfg;
    logic [7:0] high_s1, high_s2, high_s3;
    logic [7:0] high_in;
    logic [7:0] low_s1, low_s2, low_s3;
    logic [7:0] low_in;

    // decode helpers
    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        return addr[5:2];
    endfunction

    function automatic logic reg_offchip(input logic [3:0] idx, input logic [7:0] mode);
        logic exp;
        exp = mode[MODE_EXPANDED_BIT];
        if (mode[MODE_PERIPH_BIT] && {1'b0, idx} < 5'(EXP_REG_COUNT) && idx != IDX_MODE_CFG
            && idx != IDX_STATUS)
            return 1'b1; // RULE7
        if ((exp || mode[MODE_PERIPH_BIT]) && (idx == IDX_HIGH_DATA || idx == IDX_HIGH_DIR
            || idx == IDX_LOW_DATA || idx == IDX_LOW_DIR))
            return 1'b1; // RULE8
        if (exp && mode[MODE_EMULATE_BIT] && (idx == IDX_CTRL_DATA || idx == IDX_CTRL_DIR))
            return 1'b1; // RULE9
        return 1'b0;
    endfunction

    logic expanded, narrow, wide_follow;
    assign expanded = mode_cfg[MODE_EXPANDED_BIT] | mode_cfg[MODE_PERIPH_BIT];
    assign narrow = mode_cfg[MODE_NARROW_BIT];
    // follow bit only matters in expanded wide mode
    assign wide_follow = mode_cfg[MODE_EXPANDED_BIT] & ~narrow & mode_cfg[MODE_FOLLOW_BIT];

    // ========================================
    // pin input synchronisers, three stages
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            high_s1 <= DATA_RESET;
            high_s2 <= DATA_RESET;
            high_s3 <= DATA_RESET;
            low_s1 <= DATA_RESET;
            low_s2 <= DATA_RESET;
            low_s3 <= DATA_RESET;
        end else begin
            high_s1 <= high_port_pins_i;
            high_s2 <= high_s1;
            high_s3 <= high_s2;
            low_s1 <= low_port_pins_i;
            low_s2 <= low_s1;
            low_s3 <= low_s2;
        end
    end

    // accept a bit once stages two and three agree
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            high_in <= DATA_RESET;
            low_in <= DATA_RESET;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (high_s2[i] == high_s3[i])
                    high_in[i] <= high_s3[i];
                if (low_s2[i] == low_s3[i])
                    low_in[i] <= low_s3[i];
            end
        end
    end

    // ========================================
    // external bus cycle engine
    typedef enum logic [1:0] {
        EBP_IDLE,
        EBP_ADDR,
        EBP_DATA,
        EBP_DONE
    } ebp_state_t;

    ebp_state_t state;
    logic [2:0] phase_cnt;
    logic [15:0] cyc_addr;
    logic [15:0] cyc_wdata;
    logic cyc_read;
    logic cyc_narrow;
    logic [1:0] cyc_size;
    logic cyc_from_apb;
    logic [15:0] cyc_rdata;
    logic enc_strobe, enc_a0, enc_rw;
    logic apb_pending;

    // apb access to an off-chip register
    logic apb_setup;
    logic apb_off;
    assign apb_setup = psel_i & ~penable_i;
    assign apb_off = reg_offchip(reg_index(paddr_i), mode_cfg);

    ebp_encode u_encode (
        .size_i(cyc_size),
        .addr0_i(cyc_addr[0]),
        .read_i(cyc_read),
        .low_byte_strobe_o(enc_strobe),
        .a0_o(enc_a0),
        .rw_o(enc_rw)
    );

    // cycle sequencer; apb off-chip requests take priority
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= EBP_IDLE;
            phase_cnt <= 3'h0;
            cyc_addr <= 16'h0000;
            cyc_wdata <= 16'h0000;
            cyc_read <= 1'b1;
            cyc_narrow <= 1'b0;
            cyc_size <= EBP_ACC_BYTE;
            cyc_from_apb <= 1'b0;
            cyc_rdata <= 16'h0000;
        end else begin
            case (state)
                EBP_IDLE: begin
                    phase_cnt <= 3'h0;
                    if (apb_setup && apb_off) begin
                        cyc_addr <= {8'h00, 2'b00, paddr_i[7:2]}; // RULE15
                        cyc_wdata <= {8'h00, pwdata_i[7:0]};
                        cyc_read <= ~pwrite_i;
                        cyc_size <= EBP_ACC_BYTE; // RULE15
                        cyc_narrow <= narrow;
                        cyc_from_apb <= 1'b1;
                        state <= EBP_ADDR;
                    end else if (cpu_req_i && expanded && !cpu_done_o) begin // req still up at done
                        cyc_addr <= cpu_addr_i;
                        cyc_wdata <= cpu_wdata_i;
                        cyc_read <= cpu_read_i;
                        cyc_from_apb <= 1'b0;
                        // narrow mode or narrow follow space: byte cycles only
                        cyc_narrow <= narrow | (wide_follow & cpu_follow_i); // RULE14 RULE3
                        if (!cpu_word_i || narrow || (wide_follow && cpu_follow_i))
                            cyc_size <= EBP_ACC_BYTE; // RULE2
                        else if (cpu_addr_i[0] && cpu_ram_i)
                            cyc_size <= EBP_ACC_MISALIGNED; // RULE6
                        else
                            cyc_size <= EBP_ACC_WORD; // RULE2 RULE1
                        state <= EBP_ADDR;
                    end
                end
                EBP_ADDR: begin
                    phase_cnt <= phase_cnt + 3'h1;
                    if (phase_cnt == 3'(BUS_CYCLE_CLKS / 2 - 1)) begin
                        phase_cnt <= 3'h0;
                        state <= EBP_DATA;
                    end
                end
                EBP_DATA: begin
                    phase_cnt <= phase_cnt + 3'h1;
                    // hold the data phase until the synchroniser shows the answer
                    if (phase_cnt == 3'(BUS_CYCLE_CLKS / 2 - 1 + PIN_SYNC_CLKS)) begin
                        if (cyc_narrow)
                            cyc_rdata <= {8'h00, high_in}; // RULE10
                        else
                            cyc_rdata <= {high_in, low_in}; // RULE1
                        state <= EBP_DONE;
                    end
                end
                EBP_DONE: begin
                    state <= EBP_IDLE;
                end
                default: state <= EBP_IDLE;
            endcase
        end
    end

    // ========================================
    // register writes
    logic apb_wr_local;
    assign apb_wr_local = psel_i & penable_i & pwrite_i & ~apb_off;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            high_byte_port_data <= DATA_RESET;
            high_byte_port_direction <= DIR_RESET; // RULE16
            low_byte_port_data <= DATA_RESET;
            low_byte_port_direction <= DIR_RESET;
            control_port_data <= DATA_RESET;
            control_port_direction <= DIR_RESET;
            mode_cfg <= MODE_RESET;
        end else if (apb_wr_local) begin
            case (reg_index(paddr_i))
                IDX_HIGH_DATA: high_byte_port_data <= pwdata_i[7:0]; // RULE11
                IDX_HIGH_DIR: high_byte_port_direction <= pwdata_i[7:0];
                IDX_LOW_DATA: low_byte_port_data <= pwdata_i[7:0];
                IDX_LOW_DIR: low_byte_port_direction <= pwdata_i[7:0];
                IDX_CTRL_DATA: control_port_data <= pwdata_i[7:0];
                IDX_CTRL_DIR: control_port_direction <= pwdata_i[7:0];
                IDX_MODE_CFG: mode_cfg <= {3'b000, pwdata_i[4:0]};
                default: ;
            endcase
        end
    end

    // ========================================
    // apb answer: local no wait state, off chip after the bus cycle
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= UNMAPPED_READ;
            apb_pending <= 1'b0;
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            if (apb_setup && !apb_off) begin
                pready_o <= 1'b1;
                case (reg_index(paddr_i))
                    IDX_HIGH_DATA: prdata_o <= {24'h00_0000, (high_byte_port_data
                        & high_byte_port_direction) | (high_in & ~high_byte_port_direction)};
                    IDX_HIGH_DIR: prdata_o <= {24'h00_0000, high_byte_port_direction};
                    IDX_LOW_DATA: prdata_o <= {24'h00_0000, (low_byte_port_data
                        & low_byte_port_direction) | (low_in & ~low_byte_port_direction)};
                    IDX_LOW_DIR: prdata_o <= {24'h00_0000, low_byte_port_direction};
                    IDX_CTRL_DATA: prdata_o <= {24'h00_0000, control_port_data};
                    IDX_CTRL_DIR: prdata_o <= {24'h00_0000, control_port_direction};
                    IDX_MODE_CFG: prdata_o <= {24'h00_0000, mode_cfg};
                    IDX_STATUS: prdata_o <= {29'h0000_0000, state != EBP_IDLE,
                        expanded, narrow};
                    default: begin
                        prdata_o <= UNMAPPED_READ;
                        pslverr_o <= 1'b1;
                    end
                endcase
            end else if (apb_setup && apb_off) begin
                apb_pending <= 1'b1;
            end else if (apb_pending && state == EBP_DONE) begin
                apb_pending <= 1'b0;
                pready_o <= 1'b1;
                prdata_o <= {24'h00_0000, cyc_rdata[7:0]};
            end
        end
    end

    // ========================================
    // cpu handshake and pins
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cpu_done_o <= 1'b0;
            cpu_rdata_o <= 16'h0000;
            high_port_pins_o <= DATA_RESET;
            high_port_pins_oe_n_o <= 8'hff;
            low_port_pins_o <= DATA_RESET;
            low_port_pins_oe_n_o <= 8'hff;
            low_byte_strobe_o <= 1'b1;
            a0_o <= 1'b0;
            rw_o <= 1'b1;
            bus_active_o <= 1'b0;
        end else begin
            cpu_done_o <= (state == EBP_DONE) && !cyc_from_apb;
            if (state == EBP_DONE && !cyc_from_apb)
                cpu_rdata_o <= cyc_rdata;
            bus_active_o <= (state == EBP_ADDR) || (state == EBP_DATA);
            if (!expanded) begin
                // general io, direction 1 drives
                high_port_pins_o <= high_byte_port_data; // RULE11
                high_port_pins_oe_n_o <= ~high_byte_port_direction; // RULE12
                low_port_pins_o <= low_byte_port_data;
                low_port_pins_oe_n_o <= ~low_byte_port_direction;
                low_byte_strobe_o <= 1'b1;
                a0_o <= 1'b0;
                rw_o <= 1'b1;
            end else if (state == EBP_ADDR) begin
                high_port_pins_o <= cyc_addr[15:8]; // RULE10
                high_port_pins_oe_n_o <= 8'h00;
                low_port_pins_o <= cyc_addr[7:0]; // RULE13
                low_port_pins_oe_n_o <= 8'h00;
                low_byte_strobe_o <= enc_strobe; // RULE2
                a0_o <= enc_a0;
                rw_o <= enc_rw;
            end else if (state == EBP_DATA) begin
                if (cyc_narrow) begin
                    // narrow: data through high port, low byte if odd, high byte if even
                    high_port_pins_o <= cyc_addr[0] ? cyc_wdata[7:0] : cyc_wdata[15:8]; // RULE14
                    high_port_pins_oe_n_o <= {8{cyc_read}};
                    low_port_pins_oe_n_o <= 8'h00; // RULE13
                end else begin
                    high_port_pins_o <= cyc_wdata[15:8];
                    high_port_pins_oe_n_o <= {8{cyc_read}};
                    low_port_pins_o <= cyc_wdata[7:0];
                    low_port_pins_oe_n_o <= {8{cyc_read}};
                end
            end else begin
                high_port_pins_oe_n_o <= 8'hff;
                low_port_pins_oe_n_o <= 8'hff;
            end
        end
    end

    // ========================================
    // checks
    property p_dir_reset;
        @(posedge core_clk_i) $fell(reset_i) |-> high_byte_port_direction == 8'h00;
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared"); // RULE16

    property p_gpio_oe;
        @(posedge core_clk_i) disable iff (reset_i)
        !expanded && $stable(mode_cfg) && $stable(high_byte_port_direction)
        |=> high_port_pins_oe_n_o == ~$past(high_byte_port_direction);
    endproperty
    a_gpio_oe: assert property (p_gpio_oe) else $error("gpio direction wrong"); // RULE12

    property p_word_strobe;
        @(posedge core_clk_i) disable iff (reset_i)
        state == EBP_ADDR && cyc_size == EBP_ACC_WORD && expanded
        |=> !low_byte_strobe_o && !a0_o;
    endproperty
    a_word_strobe: assert property (p_word_strobe) else $error("word strobe wrong"); // RULE5

    property p_byte_strobe;
        @(posedge core_clk_i) disable iff (reset_i)
        state == EBP_ADDR && cyc_size == EBP_ACC_BYTE && expanded
        |=> low_byte_strobe_o == !cyc_addr[0] && a0_o == cyc_addr[0] && rw_o == cyc_read;
    endproperty
    a_byte_strobe: assert property (p_byte_strobe) else $error("byte strobe wrong"); // RULE4

    property p_misaligned;
        @(posedge core_clk_i) disable iff (reset_i)
        state == EBP_IDLE && !(apb_setup && apb_off) && cpu_req_i && expanded
        && cpu_word_i && !narrow && !wide_follow && cpu_addr_i[0] && !cpu_ram_i
        |=> cyc_size != EBP_ACC_MISALIGNED;
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned not ram"); // RULE6

    property p_addr_out;
        @(posedge core_clk_i) disable iff (reset_i)
        expanded && state == EBP_ADDR |=> high_port_pins_o == cyc_addr[15:8]
        && low_port_pins_o == cyc_addr[7:0];
    endproperty
    a_addr_out: assert property (p_addr_out) else $error("address not on pins"); // RULE10

    property p_offchip_no_write;
        @(posedge core_clk_i) disable iff (reset_i)
        psel_i && penable_i && pwrite_i && expanded && reg_index(paddr_i) == IDX_HIGH_DIR
        |=> $stable(high_byte_port_direction);
    endproperty
    a_offchip_no_write: assert property (p_offchip_no_write) else $error("removed reg written"); // RULE8

    property p_offchip_cycle;
        @(posedge core_clk_i) disable iff (reset_i)
        state == EBP_IDLE && apb_setup && apb_off |=> state == EBP_ADDR ##[1:8] state == EBP_DONE;
    endproperty
    a_offchip_cycle: assert property (p_offchip_cycle) else $error("no external cycle"); // RULE15

endmodule // ebp_port

//--- sim/ebp_ext_model.sv
`timescale 1ns/1ps
// ========================================
// external bus partner: answers reads with the inverted address, latches address and write data
module ebp_ext_model (
    input wire logic core_clk_i,
    input wire logic bus_active_i,
    input wire logic rw_i,
    input wire logic [7:0] hi_i,
    input wire logic [7:0] hi_oe_n_i,
    input wire logic [7:0] lo_i,
    input wire logic [7:0] lo_oe_n_i,
    output logic [7:0] hi_o,
    output logic [7:0] lo_o,
    output logic [15:0] addr_q,
    output logic [15:0] wr_q
);
    logic act_q = 1'b0;
    logic [15:0] last = 16'h0000;
    logic rd;
    // answer reads with the inverted address, released lines show inverse of last drive
    assign rd = bus_active_i && rw_i && hi_oe_n_i == 8'hff;
    assign hi_o = rd ? ~addr_q[15:8] : ~last[15:8];
    assign lo_o = rd ? ~addr_q[7:0] : ~last[7:0];
    // latch address at cycle start, last driven word as write data
    always_ff @(posedge core_clk_i) begin
        act_q <= bus_active_i;
        if (bus_active_i && !act_q) addr_q <= {hi_i, lo_i};
        if (bus_active_i && hi_oe_n_i == 8'h00) wr_q <= {hi_i, lo_i};
        if (rd) last <= ~addr_q;
    end
endmodule // ebp_ext_model

//--- sim/external_bus_port_control_bench.sv
`timescale 1ns/1ps
module external_bus_port_control_bench
    import ebp_pkg::*;
;
    logic core_clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, q;
    logic pready_o, pslverr_o, err, ext, cpu_req_i = 0, cpu_read_i = 0, cpu_word_i = 0;
    logic cpu_ram_i = 0, cpu_follow_i = 0, cpu_done_o, low_byte_strobe_o, a0_o, rw_o;
    logic [15:0] cpu_addr_i = 0, cpu_wdata_i = 0, cpu_rdata_o, addr_q, wr_q, a, d;
    logic [7:0] hi_i, hi_o, hi_oe_n, lo_i, lo_o, lo_oe_n, dir, dat;
    logic bus_active_o, rd, wd, ram, fl, nb;
    logic [7:0] mode_tab [5] = '{8'h00, 8'h01, 8'h11, 8'h01, 8'h04};
    logic [7:0] addr_tab [5] = '{8'h20, 8'h20, 8'h20, 8'h04, 8'h20};
    int err_total = 0, checks = 0, cyc = 0, kind;
    ebp_port i_ebp_port (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_req_i(cpu_req_i),
        .cpu_addr_i(cpu_addr_i), .cpu_read_i(cpu_read_i), .cpu_word_i(cpu_word_i),
        .cpu_ram_i(cpu_ram_i), .cpu_follow_i(cpu_follow_i), .cpu_wdata_i(cpu_wdata_i),
        .cpu_done_o(cpu_done_o), .cpu_rdata_o(cpu_rdata_o), .high_port_pins_i(hi_i),
        .high_port_pins_o(hi_o), .high_port_pins_oe_n_o(hi_oe_n), .low_port_pins_i(lo_i),
        .low_port_pins_o(lo_o), .low_port_pins_oe_n_o(lo_oe_n),
        .low_byte_strobe_o(low_byte_strobe_o), .a0_o(a0_o), .rw_o(rw_o),
        .bus_active_o(bus_active_o));
    ebp_ext_model i_ebp_ext_model (.core_clk_i(core_clk_i), .bus_active_i(bus_active_o),
        .rw_i(rw_o), .hi_i(hi_o), .hi_oe_n_i(hi_oe_n), .lo_i(lo_o), .lo_oe_n_i(lo_oe_n),
        .hi_o(hi_i), .lo_o(lo_i), .addr_q(addr_q), .wr_q(wr_q));
    // ========================================
    // clock, timeout and checking
    always #2.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task stop_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // expected strobe, a0, rw for an access kind
    function automatic logic [2:0] enc(input logic w, r, odd, rdn);
        if (r) return {2'b11, rdn};
        if (w) return {2'b00, rdn};
        return {~odd, odd, rdn};
    endfunction
    // ========================================
    // apb master and cpu request drivers
    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd32);
        int n;
        n = 0;
        ext = 0;
        @(posedge core_clk_i);
        psel_i <= 1;
        pwrite_i <= wr;
        paddr_i <= ad;
        pwdata_i <= wd32;
        @(posedge core_clk_i);
        penable_i <= 1;
        do begin
            @(posedge core_clk_i);
            n++;
            if (bus_active_o === 1'b1) ext = 1;
        end while (pready_o !== 1'b1);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task cpu(input logic r, w, m, f, input logic [15:0] ad, dd);
        int n;
        logic [2:0] s;
        n = 0;
        @(posedge core_clk_i);
        cpu_req_i <= 1;
        cpu_read_i <= r;
        cpu_word_i <= w;
        cpu_ram_i <= m;
        cpu_follow_i <= f;
        cpu_addr_i <= ad;
        cpu_wdata_i <= dd;
        do begin
            @(posedge core_clk_i);
            n++;
            if (n == 5) s = {low_byte_strobe_o, a0_o, rw_o};
        end while (cpu_done_o !== 1'b1 && n < 40);
        cpu_req_i <= 0;
        chk(cpu_done_o, 1);
        chk(s, enc(w, m, ad[0], r));
    endtask
    // ========================================
    // test sequence
    initial begin
        void'($urandom(62772));
        repeat (4) @(posedge core_clk_i);
        reset_i <= 0;
        chk(hi_oe_n, 8'hff);
        apb(0, 8'h08, 0);
        chk(q, DIR_RESET);
        $display("test reset done");
        {dir, dat} = 16'($urandom);
        apb(1, 8'h08, {24'h0, dir});
        apb(1, 8'h00, {24'h0, dat});
        repeat (6) @(posedge core_clk_i);
        chk(hi_oe_n, 8'(~dir));
        chk(hi_o & dir, dat & dir);
        apb(0, 8'h00, 0);
        chk(q, {24'h0, (dat & dir) | ~dir});
        apb(0, 8'h3c, 0);
        chk(err, 1'b1);
        chk(q, UNMAPPED_READ);
        $display("test general io done");
        for (int i = 0; i < 5; i++) begin
            apb(1, 8'h30, {24'h0, mode_tab[i]});
            if (i == 3) apb(1, 8'h08, {24'h0, ~dir});
            apb(0, addr_tab[i], 0);
            chk(ext, i >= 2);
        end
        $display("test mapping done");
        for (int i = 0; i < 48; i++) begin
            if (i == 0) apb(1, 8'h30, 32'h01);
            if (i == 32) apb(1, 8'h30, 32'h09);
            if (i == 40) apb(1, 8'h30, 32'h0b);
            kind = i < 8 ? i / 2 : (i < 32 ? $urandom % 4 : $urandom % 2);
            rd = i < 8 ? i[0] : 1'($urandom);
            fl = 1'($urandom);
            nb = i >= 40 || (i >= 32 && fl);
            wd = kind >= 2;
            ram = kind == 3;
            a = 16'($urandom);
            a[0] = kind == 1 || ram || (kind == 2 && 1'($urandom));
            d = 16'($urandom);
            cpu(rd, wd, ram, fl, a, d);
            if (wd && !ram && rd) chk(cpu_rdata_o, 16'(~a));
            if (wd && !ram && !rd) chk(wr_q, d);
            if (nb && rd) chk(cpu_rdata_o, {8'h00, ~a[15:8]});
            if (nb && !rd) chk(wr_q, {a[0] ? d[7:0] : d[15:8], a[7:0]});
        end
        apb(1, 8'h30, 32'h00);
        apb(0, 8'h08, 0);
        chk(q, {24'h0, dir});
        $display("test bus cycles done");
        stop_test();
    end
endmodule // external_bus_port_control_bench
